// ===== common/wake_timer_pkg.sv
// Package for the wake-up timer serial target port.
// Holds the bus address, pointer layout, debounce and tick constants.
// Assumes a single 20 MHz system clock.
package wake_timer_pkg;

    // ****************************************
    // Bus framing
    // ****************************************
    localparam logic [6:0] TARGET_ADDR = 7'h32;  // Seven-bit target address
    localparam int REG_BYTES = 3;                // Bytes per register
    localparam logic [7:0] FILL_BYTE = 8'hFF;    // Read past end of register
    localparam int PTR_BIT = 7;                  // Pointer bit in second byte
    localparam int RW_BIT = 0;                   // Direction bit in address byte

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 20000000;            // System clock rate
    localparam int TICK_HZ = 8;                  // Debounce sampling rate
    localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam int DEB_SAMPLES = 3;              // Agreeing samples needed
    localparam logic DEB_RESET = 1'b0;           // Debounced level at reset

    // ****************************************
    // Protocol states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,   // Waiting for a start
        ST_ADDR = 3'b001,   // Shifting the address byte
        ST_RX = 3'b010,     // Shifting a written byte
        ST_TX = 3'b011,     // Shifting a read byte out
        ST_ACK = 3'b100,    // Driving acknowledge
        ST_MACK = 3'b101,   // Sampling the master's acknowledge
        ST_SKIP = 3'b110    // Not addressed, byte refused or read ended; released
    } port_state_t;

endpackage

// ===== hdl/wake_timer_port.sv
// Serial target port of a low-power wake-up timer.
// Assumes scl/sda/clear pins are asynchronous; timer core gives the count.
`timescale 1ns/1ps
module wake_timer_port
    import wake_timer_pkg::*;
#(
    // Debounce tick length in clocks; a bench may shorten it
    parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Serial bus pins (open drain data)
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // External clear pin, active low
    input wire logic clear_n_i,
    // Timer core side
    input wire logic [23:0] elapsed_count_i,
    output logic [23:0] alarm_match_value_o,
    output logic alarm_write_o,
    output logic clear_n_deb_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] meta_r;  // First stage, read only by second stage
    logic [2:0] sync_r;  // Second stage: scl, sda, clear
    logic [2:0] sync_nxt;
    logic scl_d_r;       // Previous synced clock
    logic sda_d_r;       // Previous synced data

    always_comb begin
        sync_nxt = meta_r;
    end

    // Two flops per pin plus history for edge finding
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            meta_r <= 3'h7;
            sync_r <= 3'h7;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            meta_r <= {clear_n_i, sda_i, scl_i};
            sync_r <= sync_nxt;
            scl_d_r <= sync_r[0];
            sda_d_r <= sync_r[1];
        end
    end

    wire scl_s = sync_r[0];
    wire sda_s = sync_r[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire drv_low = ~sda_oe_n_o & ~sda_o;
    // Conditions only with clock steady high, and not while we pull low
    wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s & ~drv_low;
    wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s & ~drv_low;

    // ****************************************
    // Clear pin debounce
    // ****************************************
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic [DEB_SAMPLES-1:0] samp_r, samp_nxt;
    logic deb_r, deb_nxt;
    wire tick = (tick_cnt_r == 32'(TICK_CYCLES_P - 1));

    // Three samples at 8 Hz; level accepted only on agreement
    always_comb begin
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
        samp_nxt = samp_r;
        deb_nxt = deb_r;
        if (tick) begin
            samp_nxt = {samp_r[DEB_SAMPLES-2:0], sync_r[2]};
            if (&samp_nxt)
                deb_nxt = 1'b1;
            else if (~|samp_nxt)
                deb_nxt = 1'b0;
        end
    end

    // Starts low, as after power-on
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            tick_cnt_r <= 32'h0;
            samp_r <= '0;
            deb_r <= DEB_RESET;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            samp_r <= samp_nxt;
            deb_r <= deb_nxt;
        end
    end
    assign clear_n_deb_o = deb_r;

    // ****************************************
    // Protocol engine
    // ****************************************
    port_state_t st_r, st_nxt;
    logic [7:0] sh_r, sh_nxt;       // Shift register
    logic [3:0] bit_r, bit_nxt;     // Bits done in byte
    logic [2:0] byte_r, byte_nxt;   // Data bytes after address
    logic rd_r, rd_nxt;             // Read direction
    logic ptr_r, ptr_nxt;           // 1 = alarm write, 0 = alarm read
    logic ackok_r, ackok_nxt;       // Ack pending byte
    logic sda_r, sda_nxt;           // Output level (0 = pull low)
    logic [23:0] alarm_r, alarm_nxt;
    logic wr_r, wr_nxt;
    logic [7:0] txb;

    // Pick next read byte; count reads only bytes 0..2 then ones
    always_comb begin
        txb = FILL_BYTE;
        if (byte_r < 3'(REG_BYTES)) begin
            // Alarm only when pointer cleared and clear pin high
            if (!ptr_r && deb_r)
                txb = alarm_r[8'(23 - 8 * byte_r) -: 8];
            else
                txb = elapsed_count_i[8'(23 - 8 * byte_r) -: 8];
        end
    end

    always_comb begin
        st_nxt = st_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        byte_nxt = byte_r;
        rd_nxt = rd_r;
        ptr_nxt = ptr_r;
        ackok_nxt = ackok_r;
        sda_nxt = sda_r;
        alarm_nxt = alarm_r;
        wr_nxt = 1'b0;
        if (stop_ev) begin
            // Stop ends access and sets pointer to 1; clear pin plays no part
            st_nxt = ST_IDLE;
            ptr_nxt = 1'b1;
            sda_nxt = 1'b1;
        end else if (start_ev) begin
            // Start or restart; pointer kept across restart
            st_nxt = ST_ADDR;
            bit_nxt = 4'h0;
            sda_nxt = 1'b1;
        end else begin
            unique case (st_r)
                ST_IDLE, ST_SKIP: begin
                    sda_nxt = 1'b1;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        bit_nxt = bit_r + 4'h1;
                    end
                    if (scl_fall && bit_r == 4'h8) begin
                        st_nxt = ST_ACK;
                        ackok_nxt = 1'b1;
                        if (st_r == ST_ADDR) begin
                            if (sh_r[7:1] != TARGET_ADDR) begin
                                st_nxt = ST_SKIP;
                                ackok_nxt = 1'b0;
                            end
                            rd_nxt = sh_r[RW_BIT];
                            byte_nxt = 3'h0;
                        end else if (byte_r == 3'h0) begin
                            ptr_nxt = sh_r[PTR_BIT];
                            ackok_nxt = deb_r | ~sh_r[PTR_BIT];
                        end else begin
                            ackok_nxt = deb_r & ptr_r;
                            if (deb_r && ptr_r && byte_r <= 3'(REG_BYTES)) begin
                                // Byte-wise update, top byte first
                                alarm_nxt[8'(23 - 8 * (byte_r - 3'h1)) -: 8]
                                    = sh_r;
                                wr_nxt = 1'b1;
                            end
                        end
                        if (st_nxt == ST_ACK) begin
                            sda_nxt = ~ackok_nxt;
                            if (!ackok_nxt)
                                st_nxt = ST_SKIP;
                        end
                        if (st_r == ST_RX)
                            byte_nxt = byte_r + 3'h1;
                    end
                end
                ST_ACK: begin
                    // After ninth pulse falls: release on a write, drive first bit on a read
                    if (scl_fall) begin
                        bit_nxt = 4'h0;
                        if (rd_r) begin
                            st_nxt = ST_TX;
                            sh_nxt = {txb[6:0], 1'b1};
                            sda_nxt = txb[7];
                        end else begin
                            st_nxt = ST_RX;
                            sda_nxt = 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == 4'h7) begin
                            st_nxt = ST_MACK;
                            sda_nxt = 1'b1;
                            // Saturate so long reads keep returning ones
                            if (byte_r != 3'h7)
                                byte_nxt = byte_r + 3'h1;
                        end else begin
                            sda_nxt = sh_r[7];
                            sh_nxt = {sh_r[6:0], 1'b1};
                        end
                    end
                end
                ST_MACK: begin
                    // Master ack continues, no-ack ends the read
                    if (scl_rise)
                        ackok_nxt = ~sda_s;
                    if (scl_fall) begin
                        bit_nxt = 4'h0;
                        if (ackok_r) begin
                            st_nxt = ST_TX;
                            sh_nxt = {txb[6:0], 1'b1};
                            sda_nxt = txb[7];
                        end else begin
                            st_nxt = ST_SKIP;
                        end
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
    end

    // Protocol registers; alarm value survives everything but reset
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            st_r <= ST_IDLE;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            byte_r <= 3'h0;
            rd_r <= 1'b0;
            ptr_r <= 1'b1;
            ackok_r <= 1'b0;
            sda_r <= 1'b1;
            alarm_r <= 24'h000000;
            wr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            byte_r <= byte_nxt;
            rd_r <= rd_nxt;
            ptr_r <= ptr_nxt;
            ackok_r <= ackok_nxt;
            sda_r <= sda_nxt;
            alarm_r <= alarm_nxt;
            wr_r <= wr_nxt;
        end
    end

    // Open drain: only ever drive low
    assign sda_o = 1'b0;
    assign sda_oe_n_o = sda_r;
    assign alarm_match_value_o = alarm_r;
    assign alarm_write_o = wr_r;

    // ****************************************
    // Checks
    // ****************************************
    a_stop_idle: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        stop_ev |=> st_r == ST_IDLE && ptr_r)
        else $error("stop did not idle");
    a_start_addr: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        start_ev && !stop_ev |=> st_r == ST_ADDR && bit_r == 4'h0)
        else $error("start not taken");
    a_skip_released: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) st_r == ST_SKIP |-> sda_oe_n_o)
        else $error("driving while not addressed");
    a_ack_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        st_r == ST_ACK |-> !sda_oe_n_o)
        else $error("ack not driven");
    a_no_cond_drv: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        drv_low |=> st_r != ST_IDLE && st_r != ST_ADDR)
        else $error("condition taken while driving");
    a_write_gated: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) wr_r |-> $past(deb_r))
        else $error("write while cleared");
    a_alarm_stable: assert property (@(posedge clk_sys_i)
        disable iff (reset_i) !wr_r |-> $stable(alarm_r))
        else $error("alarm changed without write");
    a_fill_ones: assert property (@(posedge clk_sys_i)
        disable iff (reset_i)
        st_r == ST_TX && byte_r >= 3'(REG_BYTES) |-> sda_oe_n_o)
        else $error("past end not ones");
    c_write: cover property (@(posedge clk_sys_i) wr_r);
    c_read: cover property (@(posedge clk_sys_i) st_r == ST_MACK);
    c_restart: cover property (@(posedge clk_sys_i)
        start_ev && st_r == ST_RX);
    c_alarm_read: cover property (@(posedge clk_sys_i)
        st_r == ST_TX && !ptr_r && deb_r);

endmodule

// ===== dv/bus_master_model.sv
// Behavioural two-wire bus master that drives the wake timer port.
// Assumes a pull-up on the data line; this model only ever pulls low.
`timescale 1ns/1ps
module bus_master_model (
    // Bus pins
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    // ****************************************
    // Idle bus: clock stands high, data released
    // ****************************************
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // One clock pulse; data moves only while clock is low
    // Long low phase leaves room for the port's three-cycle answer
    task automatic bit_cycle(input logic b, output logic s);
        scl_o = 1'b0;
        #50 sda_low_o = ~b;
        #200 scl_o = 1'b1;
        #140 s = sda_i;
        #10;
    endtask

    // Data falls with clock high; also a restart
    task automatic start_cond();
        scl_o = 1'b0;
        #50 sda_low_o = 1'b0;
        #200 scl_o = 1'b1;
        #150 sda_low_o = 1'b1;
        #150;
    endtask

    // Data rises with clock high
    task automatic stop_cond();
        scl_o = 1'b0;
        #50 sda_low_o = 1'b1;
        #200 scl_o = 1'b1;
        #150 sda_low_o = 1'b0;
        #150;
    endtask

    // Address, pointer or data byte, top bit first, ack on ninth
    // Pointer byte layout is chosen by the caller
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    // Read byte; acks all but the last one
    task automatic read_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(last, s);
    endtask

    // Nine released clocks to free a stuck data line
    task automatic nine_clocks();
        logic s;
        for (int i = 0; i < 9; i++) begin
            bit_cycle(1'b1, s);
        end
    endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the wake timer serial target port.
// Assumes a shortened debounce tick so the clear pin can be exercised.
`timescale 1ns/1ps
module tb;
    import wake_timer_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys_i, reset_i, clear_n_i, scl, m_low;
    logic [23:0] elapsed_count_i;
    logic sda_o, sda_oe_n_o, alarm_write_o, clear_n_deb_o;
    logic [23:0] alarm_match_value_o;
    wire sda_w;
    int errors, checked, writes;

    // Open-drain data line with pull-up
    assign sda_w = ~(m_low | (~sda_oe_n_o & ~sda_o));

    wake_timer_port #(.TICK_CYCLES_P(20)) dut_u (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .clear_n_i(clear_n_i),
        .elapsed_count_i(elapsed_count_i),
        .alarm_match_value_o(alarm_match_value_o),
        .alarm_write_o(alarm_write_o), .clear_n_deb_o(clear_n_deb_o));
    bus_master_model m_u (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_w));

    // Clock and alarm write pulse counter
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        if (alarm_write_o === 1'b1) begin
            writes++;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic set_count(input logic [23:0] v);
        @(posedge clk_sys_i);
        #1 elapsed_count_i = v;
    endtask

    // Address byte, then four bytes back: three of v, then fill
    task automatic read_check(input logic [23:0] v);
        logic a;
        logic [7:0] b;
        m_u.write_byte({TARGET_ADDR, 1'b1}, a);
        check(24'(a), 24'h1);
        for (int i = 0; i < 4; i++) begin
            m_u.read_byte(i == 3, b);
            check(24'(b), i < 3 ? 24'(v[23 - 8 * i -: 8]) : 24'hFF);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_count_read();
        set_count(24'h5A3C96);
        m_u.start_cond();
        read_check(24'h5A3C96);
        m_u.stop_cond();
    endtask

    // Dummy write, restart, read: clear low returns the count
    task automatic s_dummy_read();
        logic a;
        set_count(24'h81C37E);
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR, 1'b0}, a);
        m_u.write_byte(8'h01, a);
        check(24'(a), 24'h1);
        m_u.start_cond();
        read_check(24'h81C37E);
        m_u.stop_cond();
    endtask

    // Alarm write refused while debounced clear is low
    task automatic s_refused_write();
        logic a;
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR, 1'b0}, a);
        check(24'(a), 24'h1);
        m_u.write_byte(8'h81, a);
        check(24'(a), 24'h0);
        m_u.write_byte(8'h12, a);
        check(24'(a), 24'h0);
        m_u.stop_cond();
        check(alarm_match_value_o, 24'h0);
        check(24'(writes), 24'h0);
        check(24'(clear_n_deb_o), 24'h0);
    endtask

    // Foreign address: line stays released
    task automatic s_mismatch();
        logic a;
        logic [7:0] b;
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR ^ 7'h01, 1'b1}, a);
        check(24'(a), 24'h0);
        m_u.read_byte(1'b1, b);
        check(24'(b), 24'hFF);
        m_u.stop_cond();
    endtask

    // Stop while the port drives zeros is ignored; recover with nine clocks
    task automatic s_recover();
        logic a, s;
        set_count(24'h000000);
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR, 1'b1}, a);
        repeat (3) m_u.bit_cycle(1'b1, s);
        m_u.stop_cond();
        check(24'(sda_w), 24'h0);
        m_u.start_cond();
        m_u.nine_clocks();
        m_u.stop_cond();
        set_count(24'hC3817E);
        m_u.start_cond();
        read_check(24'hC3817E);
        m_u.stop_cond();
    endtask

    // Clear high: debounce, alarm write, alarm read, stop sets pointer back to 1
    task automatic s_alarm();
        logic a;
        logic [23:0] v;
        v = 24'hA55A3C;
        clear_n_i = 1'b1;
        repeat (100) @(posedge clk_sys_i);
        #1 check(24'(clear_n_deb_o), 24'h1);
        // Short low glitch must not pass the debounce
        clear_n_i = 1'b0;
        repeat (10) @(posedge clk_sys_i);
        #1 clear_n_i = 1'b1;
        repeat (70) @(posedge clk_sys_i);
        #1 check(24'(clear_n_deb_o), 24'h1);
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR, 1'b0}, a);
        check(24'(a), 24'h1);
        m_u.write_byte(8'h81, a);
        check(24'(a), 24'h1);
        for (int i = 0; i < 3; i++) begin
            m_u.write_byte(v[23 - 8 * i -: 8], a);
            check(24'(a), 24'h1);
        end
        m_u.stop_cond();
        check(alarm_match_value_o, 24'hA55A3C);
        check(24'(writes), 24'h3);
        m_u.start_cond();
        m_u.write_byte({TARGET_ADDR, 1'b0}, a);
        m_u.write_byte(8'h01, a);
        check(24'(a), 24'h1);
        m_u.start_cond();
        read_check(24'hA55A3C);
        m_u.stop_cond();
        set_count(24'h3C5AA5);
        m_u.start_cond();
        read_check(24'h3C5AA5);
        m_u.stop_cond();
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        reset_i = 1'b1;
        clear_n_i = 1'b0;
        elapsed_count_i = 24'h0;
        errors = 0;
        checked = 0;
        writes = 0;
        repeat (10) @(posedge clk_sys_i);
        #1 reset_i = 1'b0;
        check(24'(sda_oe_n_o), 24'h1);
        check(alarm_match_value_o, 24'h0);
        repeat (3) @(posedge clk_sys_i);
        s_count_read();
        s_dummy_read();
        s_refused_write();
        s_mismatch();
        s_recover();
        s_alarm();
        end_of_test();
    end

    // Whole run needs well under half a millisecond
    initial begin
        #1000000;
        errors++;
        end_of_test();
    end
endmodule
